// *** rtl/leak_pkg.sv ***
// Shared constants and types of the leak status framer and pulse encoder
`default_nettype none
package leak_pkg;
	// Clock and times in their own units
	localparam int unsigned CLK_HZ = 100_000_000;
	localparam int unsigned CYC_PER_US = CLK_HZ / 1_000_000;
	localparam int unsigned FIRST_MSG_MS = 700;
	localparam int unsigned MSG_PERIOD_MS = 100;
	localparam int unsigned PWM_PERIOD_US = 255;
	localparam int unsigned PW_ERROR_US = 10;
	localparam int unsigned FIRST_MSG_CYC = FIRST_MSG_MS * (CLK_HZ / 1000);
	localparam int unsigned MSG_PERIOD_CYC = MSG_PERIOD_MS * (CLK_HZ / 1000);
	localparam int unsigned PWM_PERIOD_CYC = PWM_PERIOD_US * CYC_PER_US;

	// Concentration coding
	localparam logic [7:0] CODE_ZERO = 8'h14;
	localparam logic [7:0] CODE_FULL = 8'hF0;
	localparam logic [16:0] PPM_STEP = 17'h0_00C8;
	localparam logic [16:0] PPM_HALF_STEP = 17'h0_0064;
	localparam logic [15:0] PPM_FULL = 16'hABE0;

	// Message layout
	localparam int unsigned MSG_BYTES = 8;
	localparam int unsigned CRC_BYTES = 6;
	localparam logic [10:0] CAN_ID_BASE = 11'h640;
	localparam logic [15:0] CRC_POLY = 16'h1021;
	localparam logic [15:0] CRC_INIT_RST = 16'hFFFF;
	localparam logic [7:0] MSGCNT_RST = 8'h01;

	// Register offsets
	localparam logic [7:0] REG_CTRL = 8'h00;
	localparam logic [7:0] REG_HEALTH = 8'h04;
	localparam logic [7:0] REG_PPM = 8'h08;
	localparam logic [7:0] REG_RAW = 8'h0C;
	localparam logic [7:0] REG_CRC_INIT = 8'h10;
	localparam logic [7:0] REG_MSGCNT = 8'h14;
	localparam logic [7:0] REG_CODE = 8'h18;
	localparam logic [7:0] REG_INFO = 8'h1C;

	// Control and health field positions
	localparam int unsigned CTRL_PWM_BIT = 0;
	localparam int unsigned CTRL_ERR_BIT = 1;
	localparam int unsigned HEALTH_REL_LSB = 3;

	// One finished status message
	typedef struct packed {
		logic [10:0] can_id;
		logic [7:0][7:0] data;
	} status_msg_t;

	// Health fields as software sets them
	typedef struct packed {
		logic [4:0] release_num;
		logic [1:0] status;
	} health_t;
endpackage
`default_nettype wire

// *** rtl/ppm_code_conv.sv ***
// Converts a ppm reading into the clamped concentration code
`default_nettype none
module ppm_code_conv (
	input wire logic clk_sys,
	input wire logic sys_rst,
	input wire logic [15:0] ppm,
	output logic [7:0] code_r
);
	logic [16:0] sum;
	logic [16:0] quot;
	logic [16:0] code_wide;

	// Round to nearest step, offset by zero code, clamp to full scale
	always_comb begin
		sum = {1'b0, ppm} + leak_pkg::PPM_HALF_STEP;
		quot = sum / leak_pkg::PPM_STEP;
		code_wide = quot + {9'h0, leak_pkg::CODE_ZERO};
	end

	always_ff @(posedge clk_sys) begin
		if (sys_rst) begin
			code_r <= leak_pkg::CODE_ZERO;
		end else if (code_wide > {9'h0, leak_pkg::CODE_FULL}) begin
			code_r <= leak_pkg::CODE_FULL;
		end else begin
			code_r <= code_wide[7:0];
		end
	end
endmodule
`default_nettype wire

// *** rtl/crc16_ccitt.sv ***
// Byte-wide CRC16 engine, polynomial 0x1021, most significant bit first
`default_nettype none
module crc16_ccitt (
	input wire logic clk_sys,
	input wire logic sys_rst,
	input wire logic init_load,
	input wire logic [15:0] init_val,
	input wire logic byte_valid,
	input wire logic [7:0] byte_in,
	output logic [15:0] crc_r
);
	// One byte through the shift register
	function automatic logic [15:0] crc_step(input logic [15:0] c,
			input logic [7:0] d);
		logic [15:0] r;
		r = c ^ {d, 8'h00};
		for (int i = 0; i < 8; i++) begin
			if (r[15]) begin
				r = {r[14:0], 1'b0} ^ leak_pkg::CRC_POLY;
			end else begin
				r = {r[14:0], 1'b0};
			end
		end
		return r;
	endfunction

	always_ff @(posedge clk_sys) begin
		if (sys_rst) begin
			crc_r <= leak_pkg::CRC_INIT_RST;
		end else if (init_load) begin
			crc_r <= init_val;
		end else if (byte_valid) begin
			crc_r <= crc_step(crc_r, byte_in);
		end
	end
endmodule
`default_nettype wire

// *** rtl/leak_status_frame_and_pwm_encoder.sv ***
// Status message framer and pulse-width encoder of the leak sensor
//
// Behaviour
// - Zero ppm is sent as concentration code 20.
// - Full scale 44000 ppm is sent as code 240.
// - Code is ppm over 200, rounded to nearest, plus 20.
// - Every message carries a 10-bit protection value.
// - Protection word starts as status bits over the code byte.
// - Add the two low message-counter bits to the protection word.
// - Then invert all ten bits and add one, keeping ten bits.
// - Low eight bits go to byte 1, top two to byte 4 bits 0-1.
// - Raw sensing-element level is 10 bits, 4 mV per step.
// - Raw high byte in byte 2, low two bits in byte 4 bits 6-7.
// - CRC16 high byte in byte 3, low byte in byte 7.
// - Sensor number from supply feeds sits in byte 4 bits 2-4.
// - Message counter rises by one after each sent frame.
// - Counter wraps from 255 to zero.
// - First transmitted counter value is one.
// - Two-bit status: 0 ok, 1 minor, 2 replace, 3 fatal.
// - Five-bit release number sits in byte 6 bits 3-7.
// - Pulse variant drives line pair dominant or recessive.
// - Pulse variant only transmits; no frames, nothing received; a frame begun before pulse mode still goes out.
// - Pulse period is fixed at 255 microseconds.
// - Recessive time 20 to 240 us, one us per 200 ppm.
// - Internal error shows as 10 us recessive time.
// - First message 700 ms after power-on, then every 100 ms.
// - Sensor number 1-7 from feeds; identifier 0x640 plus 8 steps.
// - Data field always eight bytes, code byte 0, protection byte 1.
`default_nettype none
module leak_status_frame_and_pwm_encoder #(
	parameter int unsigned FIRST_MSG_CYC = leak_pkg::FIRST_MSG_CYC,
	parameter int unsigned MSG_PERIOD_CYC = leak_pkg::MSG_PERIOD_CYC,
	parameter int unsigned PWM_PERIOD_CYC = leak_pkg::PWM_PERIOD_CYC,
	parameter int unsigned CYC_PER_US = leak_pkg::CYC_PER_US
) (
	input wire logic clk_sys,
	input wire logic sys_rst,
	// Register port
	input wire logic [7:0] reg_addr,
	input wire logic [31:0] reg_wdata,
	input wire logic reg_wr,
	input wire logic reg_rd,
	output logic [31:0] reg_rdata,
	// Supply feed pins
	input wire logic supply_feed_bit0,
	input wire logic supply_feed_bit1,
	input wire logic supply_feed_bit2,
	// Message stream to the bus controller
	output logic msg_valid,
	input wire logic msg_ready,
	output leak_pkg::status_msg_t msg_r,
	// Pulse output toward the line driver
	output logic line_dominant_r,
	output logic pwm_active
);
	typedef enum {
		S_WAIT,
		S_CRC,
		S_FILL,
		S_SEND
	} frame_state_t;

	frame_state_t state_r;
	logic pwm_mode_r;
	logic int_error_r;
	leak_pkg::health_t health_r;
	logic [15:0] ppm_r;
	logic [9:0] raw_level_r;
	logic [15:0] crc_init_r;
	logic [7:0] msgcnt_r;
	logic [7:0] code;
	logic [15:0] crc;
	logic [2:0] feed_meta_r;
	logic [2:0] feed_sync_r;
	logic [2:0] sensor_num;
	logic [10:0] can_id;
	logic [31:0] tick_cnt_r;
	logic started_r;
	logic tick;
	logic [2:0] crc_idx_r;
	logic crc_load;
	logic crc_feed;
	logic [7:0] crc_byte;
	logic [9:0] prot_word;
	logic [14:0] pwm_cnt_r;
	logic [14:0] pw_cyc_r;
	logic [7:0] pw_us;
	logic [14:0] pw_cyc;
	logic [31:0] rdata_nxt;

	////////////////////////////////////////////////////////////////////////
	// Register writes

	// Control and setting registers
	always_ff @(posedge clk_sys) begin
		if (sys_rst) begin
			pwm_mode_r <= 1'b0;
			int_error_r <= 1'b0;
			health_r <= '0;
			ppm_r <= 16'h0000;
			raw_level_r <= 10'h000;
			crc_init_r <= leak_pkg::CRC_INIT_RST;
		end else if (reg_wr) begin
			case (reg_addr)
				leak_pkg::REG_CTRL: begin
					pwm_mode_r <= reg_wdata[leak_pkg::CTRL_PWM_BIT];
					int_error_r <= reg_wdata[leak_pkg::CTRL_ERR_BIT];
				end
				leak_pkg::REG_HEALTH: begin
					health_r.status <= reg_wdata[1:0];
					health_r.release_num <=
						reg_wdata[leak_pkg::HEALTH_REL_LSB +: 5];
				end
				leak_pkg::REG_PPM: begin
					ppm_r <= reg_wdata[15:0];
				end
				leak_pkg::REG_RAW: begin
					raw_level_r <= reg_wdata[9:0];
				end
				leak_pkg::REG_CRC_INIT: begin
					crc_init_r <= reg_wdata[15:0];
				end
				default: begin
				end
			endcase
		end
	end

	////////////////////////////////////////////////////////////////////////
	// Register reads

	// Read mux, unmapped offsets read zero
	always_comb begin
		rdata_nxt = 32'h0000_0000;
		case (reg_addr)
			leak_pkg::REG_CTRL: begin
				rdata_nxt[leak_pkg::CTRL_PWM_BIT] = pwm_mode_r;
				rdata_nxt[leak_pkg::CTRL_ERR_BIT] = int_error_r;
			end
			leak_pkg::REG_HEALTH: begin
				rdata_nxt[1:0] = health_r.status;
				rdata_nxt[leak_pkg::HEALTH_REL_LSB +: 5] =
					health_r.release_num;
			end
			leak_pkg::REG_PPM: begin
				rdata_nxt[15:0] = ppm_r;
			end
			leak_pkg::REG_RAW: begin
				rdata_nxt[9:0] = raw_level_r;
			end
			leak_pkg::REG_CRC_INIT: begin
				rdata_nxt[15:0] = crc_init_r;
			end
			leak_pkg::REG_MSGCNT: begin
				rdata_nxt[7:0] = msgcnt_r;
			end
			leak_pkg::REG_CODE: begin
				rdata_nxt[7:0] = code;
				rdata_nxt[17:8] = prot_word;
			end
			leak_pkg::REG_INFO: begin
				rdata_nxt[2:0] = sensor_num;
				rdata_nxt[3] = started_r;
				rdata_nxt[26:16] = can_id;
			end
			default: begin
			end
		endcase
	end

	// Read data one cycle after the strobe, held only there
	always_ff @(posedge clk_sys) begin
		if (sys_rst) begin
			reg_rdata <= 32'h0000_0000;
		end else if (reg_rd) begin
			reg_rdata <= rdata_nxt;
		end else begin
			reg_rdata <= 32'h0000_0000;
		end
	end

	////////////////////////////////////////////////////////////////////////
	// Supply feeds and identity

	// Two-stage synchroniser on the feed pins
	always_ff @(posedge clk_sys) begin
		if (sys_rst) begin
			feed_meta_r <= 3'h0;
			feed_sync_r <= 3'h0;
		end else begin
			feed_meta_r <= {supply_feed_bit2, supply_feed_bit1,
				supply_feed_bit0};
			feed_sync_r <= feed_meta_r;
		end
	end

	// Feeds form the sensor number, identifier steps by eight
	assign sensor_num = feed_sync_r;
	assign can_id = leak_pkg::CAN_ID_BASE +
		{5'h00, sensor_num - 3'h1, 3'h0};

	////////////////////////////////////////////////////////////////////////
	// Concentration code and protection value

	// Rounded, offset and clamped code
	ppm_code_conv u_conv (
		.clk_sys(clk_sys),
		.sys_rst(sys_rst),
		.ppm(ppm_r),
		.code_r(code)
	);

	// Status over code, add counter bits, then negate
	always_comb begin
		prot_word = {health_r.status, code};
		prot_word = prot_word + {8'h00, msgcnt_r[1:0]};
		prot_word = ~prot_word + 10'h001;
	end

	////////////////////////////////////////////////////////////////////////
	// Message timing

	// 700 ms to the first message, 100 ms between the rest
	always_ff @(posedge clk_sys) begin
		if (sys_rst) begin
			tick_cnt_r <= 32'h0000_0000;
			started_r <= 1'b0;
		end else if (tick) begin
			tick_cnt_r <= 32'h0000_0000;
			started_r <= 1'b1;
		end else begin
			tick_cnt_r <= tick_cnt_r + 32'h0000_0001;
		end
	end

	// Send slot reached
	assign tick = started_r ? (tick_cnt_r == MSG_PERIOD_CYC - 1) :
		(tick_cnt_r == FIRST_MSG_CYC - 1);

	////////////////////////////////////////////////////////////////////////
	// Frame builder

	// Bytes covered by the checksum: all but the two checksum bytes
	always_comb begin
		case (crc_idx_r)
			3'h0: crc_byte = msg_r.data[0];
			3'h1: crc_byte = msg_r.data[1];
			3'h2: crc_byte = msg_r.data[2];
			3'h3: crc_byte = msg_r.data[4];
			3'h4: crc_byte = msg_r.data[5];
			default: crc_byte = msg_r.data[6];
		endcase
	end

	assign crc_load = (state_r == S_WAIT) && tick && !pwm_mode_r;
	assign crc_feed = (state_r == S_CRC);

	// Checksum over the assembled bytes
	crc16_ccitt u_crc (
		.clk_sys(clk_sys),
		.sys_rst(sys_rst),
		.init_load(crc_load),
		.init_val(crc_init_r),
		.byte_valid(crc_feed),
		.byte_in(crc_byte),
		.crc_r(crc)
	);

	// Frame sequence; pulse variant starts no frames, one begun before pulse mode still goes out
	always_ff @(posedge clk_sys) begin
		if (sys_rst) begin
			state_r <= S_WAIT;
			crc_idx_r <= 3'h0;
		end else begin
			case (state_r)
				S_WAIT: begin
					crc_idx_r <= 3'h0;
					if (crc_load) begin
						state_r <= S_CRC;
					end
				end
				S_CRC: begin
					crc_idx_r <= crc_idx_r + 3'h1;
					if (crc_idx_r == 3'(leak_pkg::CRC_BYTES - 1)) begin
						state_r <= S_FILL;
					end
				end
				S_FILL: begin
					state_r <= S_SEND;
				end
				S_SEND: begin
					if (msg_ready) begin
						state_r <= S_WAIT;
					end
				end
				default: begin
					state_r <= S_WAIT;
				end
			endcase
		end
	end

	// Eight data bytes and identifier
	always_ff @(posedge clk_sys) begin
		if (sys_rst) begin
			msg_r <= '0;
		end else if (crc_load) begin
			msg_r.can_id <= can_id;
			msg_r.data[0] <= code;
			msg_r.data[1] <= prot_word[7:0];
			msg_r.data[2] <= raw_level_r[9:2];
			msg_r.data[3] <= 8'h00;
			msg_r.data[4] <= {raw_level_r[1:0], 1'b0, sensor_num,
				prot_word[9:8]};
			msg_r.data[5] <= msgcnt_r;
			msg_r.data[6] <= {health_r.release_num, health_r.status,
				1'b0};
			msg_r.data[7] <= 8'h00;
		end else if (state_r == S_FILL) begin
			msg_r.data[3] <= crc[15:8];
			msg_r.data[7] <= crc[7:0];
		end
	end

	assign msg_valid = (state_r == S_SEND);

	// Counter starts at one, steps after each frame, wraps
	always_ff @(posedge clk_sys) begin
		if (sys_rst) begin
			msgcnt_r <= leak_pkg::MSGCNT_RST;
		end else if (msg_valid && msg_ready) begin
			msgcnt_r <= msgcnt_r + 8'h01;
		end
	end

	////////////////////////////////////////////////////////////////////////
	// Pulse output

	// Recessive width in us equals the code, or the error width
	assign pw_us = int_error_r ? 8'(leak_pkg::PW_ERROR_US) : code;
	assign pw_cyc = 15'(pw_us * CYC_PER_US);
	assign pwm_active = pwm_mode_r;

	// Fixed period counter, width latched at each period start
	always_ff @(posedge clk_sys) begin
		if (sys_rst || !pwm_mode_r) begin
			pwm_cnt_r <= 15'h0000;
			pw_cyc_r <= pw_cyc;
		end else if (pwm_cnt_r == 15'(PWM_PERIOD_CYC - 1)) begin
			pwm_cnt_r <= 15'h0000;
			pw_cyc_r <= pw_cyc;
		end else begin
			pwm_cnt_r <= pwm_cnt_r + 15'h0001;
		end
	end

	// Recessive first, dominant for the rest of the period
	always_ff @(posedge clk_sys) begin
		if (sys_rst || !pwm_mode_r) begin
			line_dominant_r <= 1'b0;
		end else begin
			line_dominant_r <= (pwm_cnt_r >= pw_cyc_r);
		end
	end
endmodule
`default_nettype wire

// *** dv/leak_status_checker.sv ***
// Port assertions of the leak status framer and pulse encoder
`default_nettype none
module leak_status_checker (
	input wire logic clk_sys,
	input wire logic sys_rst,
	input wire logic msg_valid,
	input wire logic msg_ready,
	input wire leak_pkg::status_msg_t msg_r,
	input wire logic line_dominant_r,
	input wire logic pwm_active
);
	default clocking @(posedge clk_sys);
	endclocking
	default disable iff (sys_rst);
	logic seen_r;
	logic [7:0] cnt_r;
	logic [9:0] prot;
	////////////////////////////////////////////////////////////////////
	// Counter value of the last accepted message
	always_ff @(posedge clk_sys) begin
		if (sys_rst) begin
			seen_r <= 1'b0;
			cnt_r <= 8'h00;
		end else if (msg_valid && msg_ready) begin
			seen_r <= 1'b1;
			cnt_r <= msg_r.data[5];
		end
	end
	// Protection value rebuilt from the sent fields
	assign prot = 10'h000 - ({msg_r.data[6][2:1], msg_r.data[0]}
		+ {8'h00, msg_r.data[5][1:0]});
	sequence s_wait;
		msg_valid && !msg_ready;
	endsequence
	sequence s_take;
		msg_valid && msg_ready;
	endsequence
	////////////////////////////////////////////////////////////////////
	a_hold_msg: assert property (
		s_wait |=> msg_valid && $stable(msg_r))
		else $error("message changed before it was taken");
	a_drop_after_take: assert property (
		s_take |=> !msg_valid)
		else $error("message stayed after handshake");
	a_count_step: assert property (
		$rose(msg_valid) && seen_r |-> msg_r.data[5] == cnt_r + 8'h01)
		else $error("message counter did not step by one");
	a_code_range: assert property (
		msg_valid |-> msg_r.data[0] >= 8'h14 && msg_r.data[0] <= 8'hF0)
		else $error("concentration code out of range");
	a_prot_value: assert property (
		msg_valid |-> {msg_r.data[4][1:0], msg_r.data[1]} == prot)
		else $error("protection value wrong");
	a_spare_zero: assert property (
		msg_valid |-> !msg_r.data[4][5] && !msg_r.data[6][0])
		else $error("spare message bit set");
	a_ident_value: assert property (
		msg_valid |-> msg_r.can_id ==
		11'h638 + {5'h00, msg_r.data[4][4:2], 3'h0})
		else $error("identifier does not match sensor number");
	a_pulse_period: assert property (
		$fell(line_dominant_r) |->
		##255 ($fell(line_dominant_r) || !pwm_active))
		else $error("pulse period wrong");
	a_quiet_off: assert property (
		!pwm_active && !$past(pwm_active) |-> !line_dominant_r)
		else $error("line driven with pulse mode off");
	a_no_frames: assert property (
		$rose(msg_valid) |-> !$past(pwm_active, 8))
		else $error("frame started in pulse mode");
endmodule
bind leak_status_frame_and_pwm_encoder leak_status_checker
	i_leak_status_checker (
	.clk_sys(clk_sys),
	.sys_rst(sys_rst),
	.msg_valid(msg_valid),
	.msg_ready(msg_ready),
	.msg_r(msg_r),
	.line_dominant_r(line_dominant_r),
	.pwm_active(pwm_active)
);
`default_nettype wire

// *** dv/vcu_model.sv ***
// Model of the control unit that takes status messages
`default_nettype none
module vcu_model (
	input wire logic clk_sys,
	input wire logic sys_rst,
	input wire logic [7:0] stall_max,
	input wire logic msg_valid,
	output var logic msg_ready
);
	timeunit 1ns;
	timeprecision 1ps;
	integer seed = 32'h0000_a5eb;
	logic [7:0] wait_r;
	////////////////////////////////////////////////////////////////////
	// Take each whole message after a random stall
	always_ff @(posedge clk_sys) begin
		if (sys_rst) begin
			msg_ready <= 1'b0;
			wait_r <= 8'h00;
		end else if (msg_valid && msg_ready) begin
			msg_ready <= 1'b0;
			wait_r <= 8'($unsigned($random(seed)) % (stall_max + 1));
		end else if (msg_valid) begin
			if (wait_r == 8'h00) begin
				msg_ready <= 1'b1;
			end else begin
				wait_r <= wait_r - 8'h01;
			end
		end
	end
endmodule
`default_nettype wire

// *** dv/leak_status_frame_and_pwm_encoder_bench.sv ***
// Self-checking bench of the leak status framer and pulse encoder
`default_nettype none
module leak_status_frame_and_pwm_encoder_bench;
	timeunit 1ns;
	timeprecision 1ps;
	logic clk_sys = 1'b0;
	logic sys_rst = 1'b1;
	logic [7:0] reg_addr = 8'h00;
	logic [31:0] reg_wdata = 32'h0000_0000;
	logic reg_wr = 1'b0;
	logic reg_rd = 1'b0;
	logic [2:0] feeds = 3'h1;
	logic [7:0] stall_max = 8'h00;
	logic [31:0] reg_rdata;
	logic msg_valid;
	logic msg_ready;
	leak_pkg::status_msg_t msg_r;
	logic line_dominant_r;
	logic pwm_active;
	integer seed = 32'h0000_a5eb;
	int mismatches = 0;
	int checked = 0;
	// Clock of 10 ns
	always #5 clk_sys = ~clk_sys;
	////////////////////////////////////////////////////////////////////
	leak_status_frame_and_pwm_encoder #(
		.FIRST_MSG_CYC(200),
		.MSG_PERIOD_CYC(100),
		.PWM_PERIOD_CYC(255),
		.CYC_PER_US(1)
	) i_leak_status_frame_and_pwm_encoder (
		.clk_sys(clk_sys),
		.sys_rst(sys_rst),
		.reg_addr(reg_addr),
		.reg_wdata(reg_wdata),
		.reg_wr(reg_wr),
		.reg_rd(reg_rd),
		.reg_rdata(reg_rdata),
		.supply_feed_bit0(feeds[0]),
		.supply_feed_bit1(feeds[1]),
		.supply_feed_bit2(feeds[2]),
		.msg_valid(msg_valid),
		.msg_ready(msg_ready),
		.msg_r(msg_r),
		.line_dominant_r(line_dominant_r),
		.pwm_active(pwm_active)
	);
	vcu_model i_vcu_model (
		.clk_sys(clk_sys),
		.sys_rst(sys_rst),
		.stall_max(stall_max),
		.msg_valid(msg_valid),
		.msg_ready(msg_ready)
	);
	////////////////////////////////////////////////////////////////////
	task automatic cmp(input logic [31:0] got, input logic [31:0] exp);
		checked++;
		if (got !== exp) begin
			mismatches++;
			$display("[ERR] %0t got %h expected %h", $time, got, exp);
		end
	endtask
	task automatic give_verdict();
		$display("compares %0d mismatches %0d", checked, mismatches);
		if (mismatches == 0 && checked > 0) begin
			$display("ALL TESTS PASSED");
		end else begin
			$display("TESTS FAILED");
		end
		$finish;
	endtask
	task automatic wr(input logic [7:0] a, input logic [31:0] d);
		@(posedge clk_sys);
		reg_wr <= 1'b1;
		reg_addr <= a;
		reg_wdata <= d;
		@(posedge clk_sys);
		reg_wr <= 1'b0;
	endtask
	task automatic rd(input logic [7:0] a, output logic [31:0] q);
		@(posedge clk_sys);
		reg_rd <= 1'b1;
		reg_addr <= a;
		@(posedge clk_sys);
		reg_rd <= 1'b0;
		@(negedge clk_sys);
		q = reg_rdata;
	endtask
	// Bounded wait for a level on the line or on msg_valid
	task automatic wait_sig(input bit on_line, input logic lvl,
		output int n);
		n = 0;
		while ((on_line ? line_dominant_r : msg_valid) !== lvl) begin
			@(negedge clk_sys);
			n++;
			if (n > 2000) begin
				mismatches++;
				$display("[ERR] %0t wait ran out", $time);
				give_verdict();
			end
		end
	endtask
	// Set a level, then measure recessive and dominant spans
	task automatic pulse(input logic [15:0] p, input logic [31:0] ctl,
		input int w);
		int lo;
		int hi;
		wr(leak_pkg::REG_PPM, {16'h0000, p});
		wr(leak_pkg::REG_CTRL, ctl);
		repeat (2) begin
			wait_sig(1'b1, 1'b1, lo);
			wait_sig(1'b1, 1'b0, lo);
			wait_sig(1'b1, 1'b1, lo);
			wait_sig(1'b1, 1'b0, hi);
		end
		cmp(lo, w);
		cmp(lo + hi, 255);
		cmp(pwm_active, ctl[0]);
	endtask
	function automatic logic [7:0] code_f(input logic [15:0] p);
		if (p >= 16'hABE0) return 8'hF0;
		return 8'((32'(p) + 32'h0000_0064) / 32'h0000_00C8 + 32'h0000_0014);
	endfunction
	function automatic logic [15:0] crc_f(input logic [47:0] b);
		logic [15:0] c;
		c = 16'hFFFF;
		for (int i = 47; i >= 0; i--) begin
			c = {c[14:0], 1'b0} ^ ((c[15] ^ b[i]) ? 16'h1021 : 16'h0000);
		end
		return c;
	endfunction
	////////////////////////////////////////////////////////////////////
	// Main sequence
	initial begin
		logic [31:0] q;
		logic [15:0] p;
		logic [4:0] rel;
		logic [9:0] raw;
		logic [2:0] sn;
		logic [7:0] cnt;
		logic [7:0] code;
		logic [9:0] pr;
		logic [15:0] crc;
		int n;
		time t0;
		time tv;
		repeat (16) @(posedge clk_sys);
		sys_rst <= 1'b0;
		t0 = $time;
		rd(leak_pkg::REG_CRC_INIT, q);
		cmp(q, 32'h0000_FFFF);
		wr(leak_pkg::REG_MSGCNT, 32'h0000_0055);
		rd(leak_pkg::REG_MSGCNT, q);
		cmp(q, 32'h0000_0001);
		rd(8'h20, q);
		cmp(q, 32'h0000_0000);
		$display("register test done");
		cnt = 8'h01;
		for (int i = 0; i < 260; i++) begin
			p = 16'($unsigned($random(seed)) % 46000);
			case (i)
				0: p = 16'h0000;
				1: p = 16'hABE0;
				2: p = 16'hFFFF;
				3: p = 16'h0064;
				4: p = 16'h0063;
				default: ;
			endcase
			rel = 5'($random(seed));
			raw = 10'($random(seed));
			sn = 3'($random(seed));
			if (sn == 3'h0) sn = 3'h7;
			@(posedge clk_sys);
			feeds <= sn;
			stall_max <= 8'(i % 24);
			wr(leak_pkg::REG_PPM, {16'h0000, p});
			wr(leak_pkg::REG_HEALTH, {24'h00_0000, rel, 1'b0, 2'(i)});
			wr(leak_pkg::REG_RAW, {22'h00_0000, raw});
			wait_sig(1'b0, 1'b1, n);
			if (i == 0) begin
				n = int'(($time - t0) / 10);
				cmp(n >= 200 && n <= 212, 1);
			end else begin
				cmp(32'(($time - tv) / 10), 100);
			end
			tv = $time;
			code = code_f(p);
			pr = 10'h000 - ({2'(i), code} + {8'h00, cnt[1:0]});
			crc = crc_f({code, pr[7:0], raw[9:2], raw[1:0], 1'b0, sn,
				pr[9:8], cnt, rel, 2'(i), 1'b0});
			cmp(msg_r.data[0], code);
			cmp(msg_r.data[1], pr[7:0]);
			cmp(msg_r.data[2], raw[9:2]);
			cmp(msg_r.data[3], crc[15:8]);
			cmp(msg_r.data[4], {raw[1:0], 1'b0, sn, pr[9:8]});
			cmp(msg_r.data[5], cnt);
			cmp(msg_r.data[6], {rel, 2'(i), 1'b0});
			cmp(msg_r.data[7], crc[7:0]);
			cmp(msg_r.can_id, 11'h638 + {5'h00, sn, 3'h0});
			wait_sig(1'b0, 1'b0, n);
			cnt = cnt + 8'h01;
		end
		rd(leak_pkg::REG_MSGCNT, q);
		cmp(q, {24'h00_0000, cnt});
		pr = 10'h000 - ({2'h3, code} + {8'h00, cnt[1:0]});
		rd(leak_pkg::REG_CODE, q);
		cmp(q, {14'h0000, pr, code});
		rd(leak_pkg::REG_INFO, q);
		cmp(q[26:16], 11'h638 + {5'h00, sn, 3'h0});
		cmp({q[31:27], q[15:0]}, {17'h0_0000, 1'b1, sn});
		wr(leak_pkg::REG_CRC_INIT, 32'h0000_1D0F);
		rd(leak_pkg::REG_CRC_INIT, q);
		cmp(q, 32'h0000_1D0F);
		$display("message test done");
		stall_max <= 8'h00;
		pulse(16'h0000, 32'h0000_0001, 20);
		pulse(16'hABE0, 32'h0000_0001, 240);
		pulse(16'h1F40, 32'h0000_0001, 60);
		pulse(16'h1F40, 32'h0000_0003, 10);
		cmp(msg_valid, 1'b0);
		wr(leak_pkg::REG_CTRL, 32'h0000_0000);
		repeat (3) @(negedge clk_sys);
		cmp(line_dominant_r, 1'b0);
		$display("pulse test done");
		give_verdict();
	end
endmodule
`default_nettype wire
